// [src/cmm_regs.svh]
// Register offsets, field positions, reset values and sizes of the CPU memory map core.
`ifndef CMM_REGS_SVH
`define CMM_REGS_SVH

`define CMM_SFR_SP      8'h81
`define CMM_SFR_DPL     8'h82
`define CMM_SFR_DPH     8'h83
`define CMM_SFR_SECOND_POINTER_LOW    8'h84
`define CMM_SFR_SECOND_POINTER_HIGH    8'h85
`define CMM_SFR_EO      8'ha2
`define CMM_SFR_PSW     8'hd0
`define CMM_SFR_ACC     8'he0
`define CMM_SFR_B       8'hf0

`define CMM_RST_BYTE    8'h00
`define CMM_SP_RST      8'h00
`define CMM_PC_RST      16'h0000
`define CMM_VEC_BASE    16'h0003
`define CMM_VEC_SHIFT   3
`define CMM_PC_W        16
`define CMM_XRAM_BYTES  3072

`define CMM_LOW_TOP     8'h7f
`define CMM_BANK_TOP    8'h1f
`define CMM_BIT_TOP     8'h2f
`define CMM_BIT_PAGE    4'h2

`define CMM_PSW_CY      7
`define CMM_PSW_AC      6
`define CMM_PSW_F0      5
`define CMM_PSW_RS1     4
`define CMM_PSW_RS0     3
`define CMM_PSW_OV      2
`define CMM_PSW_F1      1
`define CMM_PSW_P       0

`define CMM_EO_TRAP     4
`define CMM_EO_MASK     8'h17
`define CMM_SEL_ONE     3'h1

`endif

// [src/cmm_pkg.sv]
// Types shared by the CPU memory map core modules.
package cmm_pkg;
  typedef enum logic [2:0] {
    cmm_rg_bank,
    cmm_rg_bits,
    cmm_rg_low,
    cmm_rg_upper,
    cmm_rg_sfr
  } cmm_region_e;
endpackage

// [src/cmm_dec_if.sv]
// Carrier between the core and its internal address decoder.
interface cmm_dec_if;
  import cmm_pkg::*;
  logic [7:0]  addr;
  logic        indirect;
  logic [7:0]  bit_addr;
  cmm_region_e region;
  logic [7:0]  bit_byte;
  logic [2:0]  bit_pos;
  modport req (output addr, output indirect, output bit_addr,
               input region, input bit_byte, input bit_pos);
  modport dec (input addr, input indirect, input bit_addr,
               output region, output bit_byte, output bit_pos);
endinterface

// [src/cmm_decode.sv]
// Internal data space decoder: byte regions and bit address mapping.
`include "cmm_regs.svh"
module cmm_decode import cmm_pkg::*; (
  cmm_dec_if.dec dif
);
  always_comb begin
    if (dif.addr > `CMM_LOW_TOP) begin
      dif.region = dif.indirect ? cmm_rg_upper : cmm_rg_sfr;
    end else if (dif.addr <= `CMM_BANK_TOP) begin
      dif.region = cmm_rg_bank;
    end else if (dif.addr <= `CMM_BIT_TOP) begin
      dif.region = cmm_rg_bits;
    end else begin
      dif.region = cmm_rg_low;
    end
  end

  always_comb begin
    dif.bit_pos = dif.bit_addr[2:0];
    if (dif.bit_addr[7]) begin
      dif.bit_byte = {dif.bit_addr[7:3], 3'h0};
    end else begin
      dif.bit_byte = {`CMM_BIT_PAGE, dif.bit_addr[6:3]};
    end
  end
endmodule // cmm_decode

// [src/cmm_core.sv]
// CPU memory map core: program counter, internal data space, core registers and data RAM.
`include "cmm_regs.svh"
module cmm_core import cmm_pkg::*; #(
  parameter int XRAM_BYTES = `CMM_XRAM_BYTES
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  dat_addr,
  input  wire logic        dat_indirect,
  input  wire logic        dat_rd,
  input  wire logic        dat_wr,
  input  wire logic [7:0]  dat_wdata,
  input  wire logic [2:0]  reg_num,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_rd,
  input  wire logic        bit_wr,
  input  wire logic        bit_wdata,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_val,
  input  wire logic        pc_inc,
  input  wire logic        irq_take,
  input  wire logic [2:0]  irq_index,
  input  wire logic        xd_rd,
  input  wire logic        xd_wr,
  input  wire logic [7:0]  xd_wdata,
  input  wire logic        xd_ptr_inc,
  output logic      [7:0]  rd_data_q,
  output logic             rd_valid_q,
  output logic      [15:0] pc_q,
  output logic      [15:0] data_pointer_pair_q,
  output logic      [7:0]  xd_rdata_q,
  output logic             xd_valid_q,
  output logic             xd_err_q,
  output logic             trap_mode_q,
  output logic      [7:0]  psw_q,
  output logic      [7:0]  acc_q,
  output logic      [7:0]  sp_q
);
  localparam int XAW = $clog2(XRAM_BYTES);

  logic [7:0]  ram_q [256];
  logic [7:0]  xram_q [XRAM_BYTES];
  logic [7:0]  dpl_q;
  logic [7:0]  dph_q;
  logic [7:0]  second_pointer_low_q;
  logic [7:0]  second_pointer_high_q;
  logic [7:0]  eo_q;
  logic [7:0]  b_q;

  logic [7:0]  sel_addr;
  logic        sel_sfr;
  logic        sel_rd;
  logic        sel_wr;
  logic        sel_bit;
  logic [2:0]  sel_pos;
  logic [7:0]  sel_wdata;
  logic [7:0]  sfr_val;
  logic [7:0]  cur_byte;
  logic [7:0]  wr_byte;
  logic [7:0]  acc_d;
  logic [7:0]  psw_d;
  logic [15:0] ptr0_d;
  logic [15:0] ptr1_d;
  logic [15:0] xd_addr;
  logic        xd_in_range;
  logic        use_one;
  logic        inc_go;
  logic [1:0]  bank;

  cmm_dec_if dif ();

  cmm_decode u_decode (
    .dif (dif)
  );

  assign dif.addr     = dat_addr;
  assign dif.indirect = dat_indirect;
  assign dif.bit_addr = bit_addr;

  assign bank = {psw_q[`CMM_PSW_RS1], psw_q[`CMM_PSW_RS0]};

  // One access per cycle is expected; if several arrive, byte access
  // wins over working register access, which wins over bit access.
  always_comb begin
    sel_addr  = dat_addr;
    sel_sfr   = 1'b0;
    sel_rd    = 1'b0;
    sel_wr    = 1'b0;
    sel_bit   = 1'b0;
    sel_pos   = dif.bit_pos;
    sel_wdata = dat_wdata;
    if (dat_rd || dat_wr) begin
      sel_sfr = (dif.region == cmm_rg_sfr);
      sel_rd  = dat_rd;
      sel_wr  = dat_wr;
    end else if (reg_rd || reg_wr) begin
      sel_addr  = {3'h0, bank, reg_num};
      sel_rd    = reg_rd;
      sel_wr    = reg_wr;
      sel_wdata = reg_wdata;
    end else if (bit_rd || bit_wr) begin
      sel_addr  = dif.bit_byte;
      sel_sfr   = dif.bit_byte[7];
      sel_rd    = bit_rd;
      sel_wr    = bit_wr;
      sel_bit   = 1'b1;
      sel_wdata = {8{bit_wdata}};
    end
  end

  always_comb begin
    unique case (sel_addr)
      `CMM_SFR_SP:   sfr_val = sp_q;
      `CMM_SFR_DPL:  sfr_val = dpl_q;
      `CMM_SFR_DPH:  sfr_val = dph_q;
      `CMM_SFR_SECOND_POINTER_LOW: sfr_val = second_pointer_low_q;
      `CMM_SFR_SECOND_POINTER_HIGH: sfr_val = second_pointer_high_q;
      `CMM_SFR_EO:   sfr_val = eo_q & `CMM_EO_MASK;
      `CMM_SFR_PSW:  sfr_val = psw_q;
      `CMM_SFR_ACC:  sfr_val = acc_q;
      `CMM_SFR_B:    sfr_val = b_q;
      default:       sfr_val = `CMM_RST_BYTE;
    endcase
  end

  assign cur_byte = sel_sfr ? sfr_val : ram_q[sel_addr];

  always_comb begin
    wr_byte = sel_wdata;
    if (sel_bit) begin
      wr_byte          = cur_byte;
      wr_byte[sel_pos] = sel_wdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sel_wr && !sel_sfr) begin
      ram_q[sel_addr] <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data_q  <= `CMM_RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= sel_rd;
      if (sel_rd) begin
        rd_data_q <= sel_bit ? {7'h00, cur_byte[sel_pos]} : cur_byte;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sp_q <= `CMM_SP_RST;
    end else if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_SP) begin
      sp_q <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      b_q <= `CMM_RST_BYTE;
    end else if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_B) begin
      b_q <= wr_byte;
    end
  end

  always_comb begin
    acc_d = acc_q;
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_ACC) begin
      acc_d = wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_q <= `CMM_RST_BYTE;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Parity is computed from the next accumulator value, so a software
  // write to the parity bit is overridden in the same cycle.
  always_comb begin
    psw_d = psw_q;
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_PSW) begin
      psw_d = wr_byte;
    end
    psw_d[`CMM_PSW_P] = ^acc_d;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      psw_q <= `CMM_RST_BYTE;
    end else begin
      psw_q <= psw_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      eo_q <= `CMM_RST_BYTE;
    end else if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_EO) begin
      eo_q <= wr_byte & `CMM_EO_MASK;
    end
  end

  assign trap_mode_q = eo_q[`CMM_EO_TRAP];

  // pointer one only for code 001
  assign use_one = (eo_q[2:0] == `CMM_SEL_ONE);

  // Post-increment belongs to the store-code move, so it is dead while
  // the trap meaning is selected.
  assign inc_go = xd_ptr_inc && !eo_q[`CMM_EO_TRAP];

  always_comb begin
    ptr0_d = {dph_q, dpl_q};
    if (inc_go && !use_one) begin
      ptr0_d = ptr0_d + 16'h0001;
    end
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_DPL) begin
      ptr0_d[7:0] = wr_byte;
    end
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_DPH) begin
      ptr0_d[15:8] = wr_byte;
    end
  end

  always_comb begin
    ptr1_d = {second_pointer_high_q, second_pointer_low_q};
    if (inc_go && use_one) begin
      ptr1_d = ptr1_d + 16'h0001;
    end
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_SECOND_POINTER_LOW) begin
      ptr1_d[7:0] = wr_byte;
    end
    if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_SECOND_POINTER_HIGH) begin
      ptr1_d[15:8] = wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dpl_q <= `CMM_RST_BYTE;
      dph_q <= `CMM_RST_BYTE;
    end else begin
      dpl_q <= ptr0_d[7:0];
      dph_q <= ptr0_d[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      second_pointer_low_q <= `CMM_RST_BYTE;
      second_pointer_high_q <= `CMM_RST_BYTE;
    end else begin
      second_pointer_low_q <= ptr1_d[7:0];
      second_pointer_high_q <= ptr1_d[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_pointer_pair_q <= {`CMM_RST_BYTE, `CMM_RST_BYTE};
    end else if (eo_q[2:0] == `CMM_SEL_ONE && !(sel_wr && sel_sfr && sel_addr == `CMM_SFR_EO)) begin
      data_pointer_pair_q <= ptr1_d;
    end else if (sel_wr && sel_sfr && sel_addr == `CMM_SFR_EO) begin
      data_pointer_pair_q <= ((wr_byte[2:0] == `CMM_SEL_ONE) ? ptr1_d : ptr0_d);
    end else begin
      data_pointer_pair_q <= ptr0_d;
    end
  end

  assign xd_addr     = use_one ? {second_pointer_high_q, second_pointer_low_q} : {dph_q, dpl_q};
  assign xd_in_range = (xd_addr < 16'(XRAM_BYTES));

  always_ff @(posedge core_clk) begin
    if (xd_wr && xd_in_range) begin
      xram_q[xd_addr[XAW-1:0]] <= xd_wdata;
    end
  end

  // Addresses beyond the fitted RAM read zero and flag an error rather
  // than alias, so runaway pointers show up in test.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      xd_rdata_q <= `CMM_RST_BYTE;
      xd_valid_q <= 1'b0;
      xd_err_q   <= 1'b0;
    end else begin
      xd_valid_q <= xd_rd;
      xd_err_q   <= (xd_rd || xd_wr) && !xd_in_range;
      if (xd_rd) begin
        xd_rdata_q <= xd_in_range ? xram_q[xd_addr[XAW-1:0]] : `CMM_RST_BYTE;
      end
    end
  end

  // no write path to code space
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc_q <= `CMM_PC_RST;
    end else if (pc_load) begin
      pc_q <= pc_load_val;
    end else if (irq_take) begin
      pc_q <= `CMM_VEC_BASE + (16'(irq_index) << `CMM_VEC_SHIFT);
    end else if (pc_inc) begin
      pc_q <= pc_q + 16'h0001;
    end
  end
endmodule // cmm_core

// [tb/cmm_core_properties.sv]
// Concurrent checks on the ports of the memory map core.
module cmm_core_properties #(
  parameter int XRAM_BYTES = 3072
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        dat_rd,
  input wire logic        dat_wr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic        bit_rd,
  input wire logic        bit_wr,
  input wire logic        pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic        pc_inc,
  input wire logic        irq_take,
  input wire logic [2:0]  irq_index,
  input wire logic        xd_rd,
  input wire logic        xd_wr,
  input wire logic        xd_ptr_inc,
  input wire logic        rd_valid_q,
  input wire logic [15:0] pc_q,
  input wire logic [15:0] data_pointer_pair_q,
  input wire logic        xd_valid_q,
  input wire logic        xd_err_q,
  input wire logic        trap_mode_q,
  input wire logic [7:0]  psw_q,
  input wire logic [7:0]  acc_q,
  input wire logic [7:0]  sp_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic rd_req;
  assign rd_req = dat_rd | (!dat_wr & reg_rd) | (!dat_wr & !dat_rd & !reg_rd & !reg_wr & bit_rd);
  // The parity flop loads from the same next accumulator value, so it never lags; only a settled value is judged.
  sequence acc_still;
    $stable(acc_q) ##1 $stable(acc_q);
  endsequence
  reset_vals_a: assert property ($fell(srst) |-> pc_q == 16'h0000 && psw_q == 8'h00 && sp_q == 8'h00 && !trap_mode_q)
    else $error("state after reset wrong");
  pc_load_a: assert property (pc_load |=> pc_q == $past(pc_load_val))
    else $error("pc load wrong");
  irq_vector_a: assert property (!pc_load && irq_take |=> pc_q == 16'h0003 + 16'($past(irq_index)) * 16'h0008)
    else $error("interrupt vector wrong");
  pc_step_a: assert property (!pc_load && !irq_take && pc_inc |=> pc_q == $past(pc_q) + 16'h0001)
    else $error("pc increment wrong");
  rd_valid_a: assert property (rd_req |=> rd_valid_q)
    else $error("read not answered");
  rd_quiet_a: assert property (!rd_req |=> !rd_valid_q)
    else $error("read answer without request");
  parity_track_a: assert property (acc_still |-> psw_q[0] == ^acc_q)
    else $error("parity does not follow accumulator");
  xd_answer_a: assert property (xd_rd |=> xd_valid_q || xd_err_q)
    else $error("data ram read not answered");
  xd_range_a: assert property (xd_rd || xd_wr |=> xd_err_q == ($past(data_pointer_pair_q) >= 16'(XRAM_BYTES)))
    else $error("data ram range flag wrong");
  ptr_inc_a: assert property (xd_ptr_inc && !trap_mode_q && !dat_wr && !bit_wr |=> data_pointer_pair_q == $past(data_pointer_pair_q) + 16'h0001)
    else $error("pointer increment wrong");
  trap_hold_a: assert property (xd_ptr_inc && trap_mode_q && !dat_wr && !bit_wr |=> $stable(data_pointer_pair_q))
    else $error("pointer moved in trap mode");
endmodule // cmm_core_properties

bind cmm_core cmm_core_properties #(.XRAM_BYTES(XRAM_BYTES)) u_props (.*);

// [tb/test_cpu_memory_map_core_regs.sv]
// Self-checking bench for the memory map core.
module test_cpu_memory_map_core_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int XB = 3072;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  dat_addr, dat_wdata, reg_wdata, bit_addr, xd_wdata, rd_data_q, xd_rdata_q, psw_q, acc_q, sp_q;
  logic        dat_indirect, dat_rd, dat_wr, reg_rd, reg_wr, bit_rd, bit_wr, bit_wdata, pc_load, pc_inc;
  logic        irq_take, xd_rd, xd_wr, xd_ptr_inc, rd_valid_q, xd_valid_q, xd_err_q, trap_mode_q;
  logic [2:0]  reg_num, irq_index;
  logic [15:0] pc_load_val, pc_q, data_pointer_pair_q;
  int          bad_count = 0;
  int          check_count = 0;

  cmm_core #(.XRAM_BYTES(XB)) dut (.*);

  initial begin
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic ind, logic [7:0] d);
    dat_addr = a;
    dat_indirect = ind;
    dat_wdata = d;
    dat_wr = 1'b1;
    @(negedge core_clk);
    dat_wr = 1'b0;
    // An idle cycle keeps two writes in a row from meeting in one time step.
    @(negedge core_clk);
  endtask

  task automatic rd(logic [7:0] a, logic ind, logic [7:0] exp, string name);
    dat_addr = a;
    dat_indirect = ind;
    dat_rd = 1'b1;
    @(negedge core_clk);
    dat_rd = 1'b0;
    check("read valid", 16'(rd_valid_q), 16'h0001);
    check(name, 16'(rd_data_q), 16'(exp));
    @(negedge core_clk);
  endtask

  task automatic t_reset;
    check("pc", pc_q, 16'h0000);
    check("psw", 16'(psw_q), 16'h0000);
    rd(8'h84, 1'b0, 8'h00, "ptr1 low");
    rd(8'h85, 1'b0, 8'h00, "ptr1 high");
    $display("reset test done");
  endtask

  task automatic t_pc;
    logic [15:0] last_vec;
    last_vec = 16'h0000;
    pc_load = 1'b1;
    pc_load_val = 16'hffff;
    @(negedge core_clk);
    pc_load = 1'b0;
    pc_inc = 1'b1;
    @(negedge core_clk);
    pc_inc = 1'b0;
    check("pc wrap", pc_q, 16'h0000);
    irq_take = 1'b1;
    for (int i = 0; i < 8; i++) begin
      irq_index = 3'(i);
      @(negedge core_clk);
      check("vector", pc_q, 16'h0003 + 16'(i) * 16'h0008);
      if (i > 0) begin
        check("slot size", pc_q - last_vec, 16'h0008);
      end
      last_vec = pc_q;
    end
    irq_take = 1'b0;
    $display("pc test done");
  endtask

  task automatic t_banks;
    for (int n = 0; n < 4; n++) begin
      wr(8'hd0, 1'b0, 8'(n << 3));
      reg_num = 3'h5;
      reg_wdata = 8'h40 + 8'(n);
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      rd(8'(n * 8 + 5), 1'b1, 8'h40 + 8'(n), "bank byte");
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check("work reg", 16'(rd_data_q), 16'h0040 + 16'(n));
      rd(8'hd0, 1'b0, 8'(n << 3), "bank bits");
    end
    $display("bank test done");
  endtask

  task automatic t_space;
    wr(8'h90, 1'b1, 8'ha5);
    wr(8'h90, 1'b0, 8'h3c);
    rd(8'h90, 1'b1, 8'ha5, "upper ram");
    rd(8'h90, 1'b0, 8'h00, "unmapped sfr");
    wr(8'h81, 1'b1, 8'h11);
    wr(8'h81, 1'b0, 8'h5e);
    rd(8'h81, 1'b1, 8'h11, "upper alias");
    check("stack", 16'(sp_q), 16'h005e);
    wr(8'h45, 1'b0, 8'h77);
    rd(8'h45, 1'b1, 8'h77, "lower ram");
    wr(8'h21, 1'b0, 8'h00);
    bit_addr = 8'h0b;
    bit_wdata = 1'b1;
    bit_wr = 1'b1;
    @(negedge core_clk);
    bit_wr = 1'b0;
    rd(8'h21, 1'b0, 8'h08, "bit byte");
    bit_rd = 1'b1;
    @(negedge core_clk);
    bit_rd = 1'b0;
    check("bit read", 16'(rd_data_q), 16'h0001);
    $display("space test done");
  endtask

  task automatic t_status;
    wr(8'he0, 1'b0, 8'h07);
    wr(8'hd0, 1'b0, 8'hfe);
    rd(8'hd0, 1'b0, 8'hff, "status odd");
    wr(8'he0, 1'b0, 8'h03);
    check("acc", 16'(acc_q), 16'h0003);
    rd(8'hd0, 1'b0, 8'hfe, "status even");
    wr(8'ha2, 1'b0, 8'hff);
    rd(8'ha2, 1'b0, 8'h17, "ext reg");
    check("trap", 16'(trap_mode_q), 16'h0001);
    wr(8'ha2, 1'b0, 8'h00);
    wr(8'hd0, 1'b0, 8'h00);
    bit_addr = 8'hd5;
    bit_wdata = 1'b1;
    bit_wr = 1'b1;
    @(negedge core_clk);
    bit_wr = 1'b0;
    check("status bit", 16'(psw_q), 16'h0020);
    wr(8'hd0, 1'b0, 8'h00);
    $display("status test done");
  endtask

  task automatic t_xram;
    wr(8'h82, 1'b0, 8'h00);
    wr(8'h83, 1'b0, 8'h01);
    check("ptr0", data_pointer_pair_q, 16'h0100);
    wr(8'h84, 1'b0, 8'hff);
    wr(8'h85, 1'b0, 8'h0b);
    wr(8'ha2, 1'b0, 8'h01);
    check("ptr1", data_pointer_pair_q, 16'h0bff);
    xd_wdata = 8'h5a;
    xd_wr = 1'b1;
    xd_ptr_inc = 1'b1;
    @(negedge core_clk);
    xd_wr = 1'b0;
    xd_ptr_inc = 1'b0;
    check("post inc", data_pointer_pair_q, 16'h0c00);
    xd_rd = 1'b1;
    @(negedge core_clk);
    xd_rd = 1'b0;
    check("range", 16'(xd_err_q), 16'h0001);
    // The increment carried into the high byte, so both bytes are put back.
    wr(8'h84, 1'b0, 8'hff);
    wr(8'h85, 1'b0, 8'h0b);
    xd_rd = 1'b1;
    @(negedge core_clk);
    xd_rd = 1'b0;
    check("xd valid", 16'(xd_valid_q), 16'h0001);
    check("xd data", 16'(xd_rdata_q), 16'h005a);
    wr(8'ha2, 1'b0, 8'h11);
    xd_ptr_inc = 1'b1;
    @(negedge core_clk);
    xd_ptr_inc = 1'b0;
    check("trap inc", data_pointer_pair_q, 16'h0bff);
    wr(8'ha2, 1'b0, 8'h00);
    check("ptr back", data_pointer_pair_q, 16'h0100);
    $display("data ram test done");
  endtask

  task automatic t_rerst;
    wr(8'hd0, 1'b0, 8'h18);
    srst = 1'b1;
    repeat (2) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    check("pc again", pc_q, 16'h0000);
    check("psw again", 16'(psw_q), 16'h0000);
    check("ptr again", data_pointer_pair_q, 16'h0000);
    rd(8'h85, 1'b0, 8'h00, "ptr1 high again");
    rd(8'ha2, 1'b0, 8'h00, "ext again");
    $display("reset again test done");
  endtask

  initial begin
    {dat_addr, dat_wdata, reg_wdata, bit_addr, xd_wdata, reg_num, irq_index, pc_load_val} = '0;
    {dat_indirect, dat_rd, dat_wr, reg_rd, reg_wr, bit_rd, bit_wr, bit_wdata} = '0;
    {pc_load, pc_inc, irq_take, xd_rd, xd_wr, xd_ptr_inc} = '0;
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_pc();
    t_banks();
    t_space();
    t_status();
    t_xram();
    t_rerst();
    stop_test();
  end

  // The whole run is about 130 cycles, so three thousand means a hang.
  initial begin
    #(50 * 3000);
    bad_count++;
    stop_test();
  end
endmodule // test_cpu_memory_map_core_regs
